//--- rtl/sd_diag_pkg.sv
// Shared constants, bit positions and types of the serial safety diagnostic block
package sd_diag_pkg;

   // Clock and serial line timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SD_BAUD = 250_000;
   localparam int unsigned BIT_CYCLES = CLK_HZ / SD_BAUD;
   localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned FRAME_GAP_BITS = 20;
   localparam int unsigned GAP_CYCLES = FRAME_GAP_BITS * BIT_CYCLES;
   localparam int unsigned COMM_TIMEOUT_MS = 100;
   localparam longint unsigned COMM_TIMEOUT_CYCLES = (64'(CLK_HZ) / 64'd1000) * 64'(COMM_TIMEOUT_MS);
   localparam int unsigned WARN_TIME_MIN = 30;
   localparam longint unsigned WARN_CYCLES = 64'(WARN_TIME_MIN) * 64'd60 * 64'(CLK_HZ);

   // Chain size and counter widths
   localparam int unsigned MAX_CHAIN = 31;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned COMM_W = 32;
   localparam int unsigned TIMER_W = 36;

   // Request byte
   localparam int unsigned REQ_DETAIL_SEL = 0;
   localparam int unsigned REQ_FAIL_RESET = 7;

   // Response byte
   localparam int unsigned RESP_SAFE_ON = 0;
   localparam int unsigned RESP_ACTUATOR = 1;
   localparam int unsigned RESP_INPUTS = 4;
   localparam int unsigned RESP_GUARD = 5;
   localparam int unsigned RESP_WARNING = 6;
   localparam int unsigned RESP_FAILURE = 7;

   // Warning and failure detail bytes
   localparam int unsigned DET_OUT1 = 0;
   localparam int unsigned DET_OUT2 = 1;
   localparam int unsigned DET_CROSS = 2;
   localparam int unsigned DET_TEMP = 3;
   localparam int unsigned DET_TARGET = 4;
   localparam int unsigned DET_INTERNAL = 5;
   localparam int unsigned DET_COMM = 6;
   localparam int unsigned DET_LOW_VOLT = 7;

   // Reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic SD_IDLE = 1'b1;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

   typedef struct packed {
      logic guard;
      logic actuator;
      logic first_safe_input;
      logic second_safe_input;
      logic out1_err;
      logic out2_err;
      logic cross_wire;
      logic over_temp;
      logic target_err;
      logic internal_err;
      logic low_voltage;
   } sense_type;

endpackage

//--- rtl/warn_timer.sv
// Persistence timer that flags a condition held for a set number of cycles
`timescale 1ns/10ps
module warn_timer #(
   parameter longint unsigned CYCLES = sd_diag_pkg::WARN_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic run_i,
   output logic expired_o
);
   import sd_diag_pkg::*;

   typedef struct packed {
      logic [TIMER_W-1:0] count;
      logic expired;
   } timer_type;

   timer_type st;
   timer_type next_st;

   // Any drop of run restarts the full period
   always_comb begin
      next_st = st;
      if (!run_i) begin
         next_st.count = '0;
         next_st.expired = 1'b0;
      end else if (st.count == TIMER_W'(CYCLES - 64'd1)) begin
         next_st.expired = 1'b1;
      end else begin
         next_st.count = st.count + TIMER_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired_o = st.expired;

endmodule

//--- rtl/serial_safety_diagnostic.sv
// Serial diagnostic chain node and safety output control of one safety switch
// Overview of operation
// - Chain carries at most 31 switches; bytes past the 31st are dropped.
// - Serial input and output pass request and response bytes along the chain.
// - Own request byte taken each frame; own response byte appended every frame.
// - Gateway communication loss never changes the safety output state.
// - Failure disables outputs at once; cleared by request bit 7 fall or guard open.
// - Output failures stay latched in detail until the next output release.
// - Warning keeps outputs on; after 30 minutes of warning they switch off.
// - Warning clears by itself as soon as its cause is gone.
// - Failure detail byte is readable while a failure is flagged, warning detail byte otherwise.
// - Response bits: 0 output on, 1 actuator, 4 inputs, 5 guard, 6 warning, 7 failure.
// - Warning detail: outputs, cross-wire, temperature, internal, comm error, low voltage.
// - Failure detail: bits 0-3 as warning, 4 target error, 5 internal error.
// - Every bit set to one means the condition or request is present.
`timescale 1ns/10ps
module serial_safety_diagnostic #(
   parameter longint unsigned WARN_CYCLES_P = sd_diag_pkg::WARN_CYCLES,
   parameter longint unsigned COMM_CYCLES_P = sd_diag_pkg::COMM_TIMEOUT_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sd_in_i,
   input wire sd_diag_pkg::sense_type sense_i,
   output logic sd_out_o,
   output logic first_safe_output_o,
   output logic second_safe_output_o,
   output logic [7:0] request_o,
   output logic [7:0] response_o,
   output logic [7:0] warning_detail_o,
   output logic [7:0] failure_detail_o,
   output logic comm_error_o
);
   import sd_diag_pkg::*;

   typedef struct packed {
      logic sd_meta;
      logic sd_sync;
      sense_type sense_meta;
      sense_type sense;
      rx_state_type rx_state;
      logic [CNT_W-1:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic [CNT_W-1:0] idle_cnt;
      logic in_frame;
      logic [4:0] byte_idx;
      logic [7:0] request;
      logic req7_prev;
      logic guard_prev;
      logic hold_valid;
      logic [7:0] hold;
      logic tx_busy;
      logic [CNT_W-1:0] tx_cnt;
      logic [3:0] tx_bit;
      logic [9:0] tx_sh;
      logic sd_out;
      logic [COMM_W-1:0] comm_cnt;
      logic comm_err;
      logic failure;
      logic safe_on;
      logic [7:0] warn_detail;
      logic [7:0] fail_detail;
      logic [7:0] response;
   } state_type;

   state_type st;
   state_type next_st;
   logic rx_done;
   logic frame_end;
   logic reset_req;
   logic guard_open;
   logic warn_cause;
   logic live_fail;
   logic warn_expired;
   logic [7:0] append_byte;

   assign frame_end = st.in_frame && (st.idle_cnt == CNT_W'(GAP_CYCLES - 1));
   // Reset acts on the falling edge of bit 7 seen between two frames
   assign reset_req = frame_end && st.req7_prev && !st.request[REQ_FAIL_RESET];
   assign guard_open = st.guard_prev && !st.sense.guard;
   assign warn_cause = st.sense.out1_err | st.sense.out2_err | st.sense.cross_wire |
                       st.sense.over_temp | st.sense.low_voltage;
   assign live_fail = st.sense.target_err | st.sense.internal_err;
   // Detail select lets the gateway fetch the detail in its own chain slot
   assign append_byte = !st.request[REQ_DETAIL_SEL] ? st.response :
                        (st.failure ? st.fail_detail : st.warn_detail);

   warn_timer #(
      .CYCLES(WARN_CYCLES_P)
   ) u_warn_timer (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .run_i(warn_cause && !st.failure),
      .expired_o(warn_expired)
   );

   always_comb begin
      next_st = st;
      rx_done = 1'b0;

      // Pin synchronisers
      next_st.sd_meta = sd_in_i;
      next_st.sd_sync = st.sd_meta;
      next_st.sense_meta = sense_i;
      next_st.sense = st.sense_meta;

      // Byte receiver: start, eight bits LSB first, stop; a bad stop bit drops the byte
      case (st.rx_state)
         RX_IDLE: begin
            if (!st.sd_sync) begin
               next_st.rx_state = RX_START;
               next_st.rx_cnt = '0;
            end
         end
         RX_START: begin
            if (st.rx_cnt == CNT_W'(HALF_BIT_CYCLES - 1)) begin
               next_st.rx_cnt = '0;
               next_st.rx_bit = '0;
               next_st.rx_state = st.sd_sync ? RX_IDLE : RX_DATA;
            end else begin
               next_st.rx_cnt = st.rx_cnt + CNT_W'(1);
            end
         end
         RX_DATA: begin
            if (st.rx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
               next_st.rx_cnt = '0;
               next_st.rx_sh = {st.sd_sync, st.rx_sh[7:1]};
               next_st.rx_bit = st.rx_bit + 3'd1;
               if (st.rx_bit == 3'd7) begin
                  next_st.rx_state = RX_STOP;
               end
            end else begin
               next_st.rx_cnt = st.rx_cnt + CNT_W'(1);
            end
         end
         RX_STOP: begin
            if (st.rx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
               next_st.rx_cnt = '0;
               next_st.rx_state = RX_IDLE;
               rx_done = st.sd_sync;
            end else begin
               next_st.rx_cnt = st.rx_cnt + CNT_W'(1);
            end
         end
         default: begin
            next_st.rx_state = RX_IDLE;
         end
      endcase

      // Line quiet time marks the end of a frame
      if (st.rx_state != RX_IDLE || !st.sd_sync) begin
         next_st.idle_cnt = '0;
      end else if (st.idle_cnt != CNT_W'(GAP_CYCLES - 1)) begin
         next_st.idle_cnt = st.idle_cnt + CNT_W'(1);
      end

      // Transmitter runs first so that a fresh load below wins the holding register
      if (!st.tx_busy) begin
         next_st.sd_out = SD_IDLE;
         if (st.hold_valid) begin
            next_st.tx_sh = {1'b1, st.hold, 1'b0};
            next_st.tx_busy = 1'b1;
            next_st.tx_cnt = '0;
            next_st.tx_bit = '0;
            next_st.hold_valid = 1'b0;
            next_st.sd_out = 1'b0;
         end
      end else if (st.tx_cnt == CNT_W'(BIT_CYCLES - 1)) begin
         next_st.tx_cnt = '0;
         if (st.tx_bit == 4'd9) begin
            next_st.tx_busy = 1'b0;
            next_st.sd_out = SD_IDLE;
         end else begin
            next_st.tx_bit = st.tx_bit + 4'd1;
            next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
            next_st.sd_out = st.tx_sh[1];
         end
      end else begin
         next_st.tx_cnt = st.tx_cnt + CNT_W'(1);
      end

      // First byte of a frame is ours, the next 30 move downstream unchanged
      if (rx_done) begin
         next_st.in_frame = 1'b1;
         if (st.byte_idx == 5'd0) begin
            next_st.request = st.rx_sh;
         end else if (st.byte_idx < 5'(MAX_CHAIN)) begin
            next_st.hold = st.rx_sh;
            next_st.hold_valid = 1'b1;
         end
         if (st.byte_idx != 5'(MAX_CHAIN)) begin
            next_st.byte_idx = st.byte_idx + 5'd1;
         end
      end

      // Own answer goes out behind the forwarded bytes
      if (frame_end) begin
         next_st.in_frame = 1'b0;
         next_st.byte_idx = '0;
         next_st.hold = append_byte;
         next_st.hold_valid = 1'b1;
         next_st.req7_prev = st.request[REQ_FAIL_RESET];
         next_st.comm_cnt = '0;
         next_st.comm_err = 1'b0;
      end else if (st.comm_cnt == COMM_W'(COMM_CYCLES_P - 64'd1)) begin
         next_st.comm_err = 1'b1;
      end else begin
         next_st.comm_cnt = st.comm_cnt + COMM_W'(1);
      end

      // Live warning detail, clears by itself with its cause
      next_st.warn_detail = '0;
      next_st.warn_detail[DET_OUT1] = st.sense.out1_err;
      next_st.warn_detail[DET_OUT2] = st.sense.out2_err;
      next_st.warn_detail[DET_CROSS] = st.sense.cross_wire;
      next_st.warn_detail[DET_TEMP] = st.sense.over_temp;
      next_st.warn_detail[DET_INTERNAL] = st.sense.internal_err;
      next_st.warn_detail[DET_COMM] = st.comm_err;
      next_st.warn_detail[DET_LOW_VOLT] = st.sense.low_voltage;

      // Failure clear first, so that any set below wins
      next_st.guard_prev = st.sense.guard;
      if (st.failure && !live_fail && (reset_req || guard_open)) begin
         next_st.failure = 1'b0;
         next_st.fail_detail[DET_TARGET] = 1'b0;
         next_st.fail_detail[DET_INTERNAL] = 1'b0;
      end
      if (live_fail) begin
         next_st.failure = 1'b1;
      end
      next_st.fail_detail[DET_TARGET] = next_st.fail_detail[DET_TARGET] | st.sense.target_err;
      next_st.fail_detail[DET_INTERNAL] = next_st.fail_detail[DET_INTERNAL] | st.sense.internal_err;
      if (warn_expired && !st.failure) begin
         next_st.failure = 1'b1;
         next_st.fail_detail[3:0] = st.fail_detail[3:0] | st.warn_detail[3:0];
      end

      // Outputs ignore the gateway link, so a lost link holds their state
      next_st.safe_on = st.sense.guard & st.sense.actuator & st.sense.first_safe_input &
                        st.sense.second_safe_input & !next_st.failure;
      // Output faults are only observable again once the outputs are released
      if (next_st.safe_on && !st.safe_on) begin
         next_st.fail_detail[3:0] = 4'h0;
      end

      // Every flag is active high
      next_st.response = '0;
      next_st.response[RESP_SAFE_ON] = next_st.safe_on;
      next_st.response[RESP_ACTUATOR] = st.sense.actuator;
      next_st.response[RESP_INPUTS] = st.sense.first_safe_input & st.sense.second_safe_input;
      next_st.response[RESP_GUARD] = st.sense.guard;
      next_st.response[RESP_WARNING] = warn_cause;
      next_st.response[RESP_FAILURE] = next_st.failure;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st <= '0;
         st.sd_meta <= SD_IDLE;
         st.sd_sync <= SD_IDLE;
         st.sd_out <= SD_IDLE;
         st.request <= BYTE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign sd_out_o = st.sd_out;
   assign first_safe_output_o = st.safe_on;
   assign second_safe_output_o = st.safe_on;
   assign request_o = st.request;
   assign response_o = st.response;
   assign warning_detail_o = st.warn_detail;
   assign failure_detail_o = st.fail_detail;
   assign comm_error_o = st.comm_err;

   a_fail_outputs_off: assert property (@(posedge clk_i) disable iff (srst_i)
      st.failure |-> !st.safe_on && !st.response[RESP_SAFE_ON])
      else $error("Safety outputs on during failure");

   a_resp_byte_map: assert property (@(posedge clk_i) disable iff (srst_i)
      st.response[RESP_FAILURE] == st.failure && st.response[RESP_SAFE_ON] == st.safe_on)
      else $error("Response byte does not match switch state");

   a_warn_auto_clear: assert property (@(posedge clk_i) disable iff (srst_i)
      !warn_cause |=> !st.response[RESP_WARNING] && st.warn_detail[3:0] == 4'h0)
      else $error("Warning did not clear with its cause");

   a_reset_clears_fail: assert property (@(posedge clk_i) disable iff (srst_i)
      st.failure && !live_fail && !warn_expired && (reset_req || guard_open) |=> !st.failure)
      else $error("Failure not cleared by reset request");

   a_warn_escalates: assert property (@(posedge clk_i) disable iff (srst_i)
      warn_expired && !st.failure |=> st.failure && !st.safe_on)
      else $error("Expired warning did not switch outputs off");

   a_own_request: assert property (@(posedge clk_i) disable iff (srst_i)
      rx_done && st.byte_idx == 5'd0 |=> st.request == $past(st.rx_sh) && !st.hold_valid)
      else $error("Own request byte not captured");

   a_append_answer: assert property (@(posedge clk_i) disable iff (srst_i)
      frame_end |=> st.hold_valid && st.hold == $past(append_byte) && st.byte_idx == 5'd0)
      else $error("Own answer not queued at frame end");

   a_chain_drop: assert property (@(posedge clk_i) disable iff (srst_i)
      rx_done && st.byte_idx == 5'(MAX_CHAIN) && !frame_end |=> $stable(st.hold))
      else $error("Byte beyond chain limit forwarded");

   a_tx_idle_high: assert property (@(posedge clk_i) disable iff (srst_i)
      !st.tx_busy |-> st.sd_out)
      else $error("Serial output low while idle");

endmodule

//--- verification/gw_model.sv
// Gateway model that sends request frames and collects answer bytes
`timescale 1ns/10ps
module gw_model (
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o
);
   import sd_diag_pkg::*;
   logic [7:0] rx_q[$];
   logic [7:0] rx_byte;
   initial begin
      line_o = SD_IDLE;
   end
   task automatic send_bit(input logic b);
      line_o = b;
      repeat (BIT_CYCLES) @(negedge clk_i);
   endtask
   // Bytes go back to back; the line rests high between frames
   task automatic send_frame(input logic [7:0] bytes[$]);
      foreach (bytes[i]) begin
         send_bit(1'b0);
         for (int k = 0; k < 8; k++) begin
            send_bit(bytes[i][k]);
         end
         send_bit(1'b1);
      end
   endtask
   // Sampling in mid-bit keeps clear of the edges of each bit
   always begin
      @(negedge line_i);
      repeat (HALF_BIT_CYCLES) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         repeat (BIT_CYCLES) @(posedge clk_i);
         rx_byte[k] = line_i;
      end
      repeat (BIT_CYCLES) @(posedge clk_i);
      if (line_i === 1'b1) begin
         rx_q.push_back(rx_byte);
      end
   end
endmodule

//--- verification/serial_safety_diagnostic_bench.sv
// Self-checking bench of the serial safety diagnostic block
`timescale 1ns/10ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("mismatch %s expected %h seen %h", what, exp, got); end end
module serial_safety_diagnostic_bench;
   import sd_diag_pkg::*;
   localparam longint unsigned WARN_T = 200;
   localparam longint unsigned COMM_T = 5000;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   wire logic sd_in_i;
   sense_type sense_i = '0;
   logic sd_out_o;
   logic first_safe_output_o;
   logic second_safe_output_o;
   logic comm_error_o;
   logic [7:0] request_o;
   logic [7:0] response_o;
   logic [7:0] warning_detail_o;
   logic [7:0] failure_detail_o;
   logic [7:0] frame[$];
   int mismatches = 0;
   int checked = 0;
   always #20 clk_i = ~clk_i;

   serial_safety_diagnostic #(.WARN_CYCLES_P(WARN_T), .COMM_CYCLES_P(COMM_T)) u_serial_safety_diagnostic (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .sd_in_i(sd_in_i),
      .sense_i(sense_i),
      .sd_out_o(sd_out_o),
      .first_safe_output_o(first_safe_output_o),
      .second_safe_output_o(second_safe_output_o),
      .request_o(request_o),
      .response_o(response_o),
      .warning_detail_o(warning_detail_o),
      .failure_detail_o(failure_detail_o),
      .comm_error_o(comm_error_o)
   );
   gw_model u_gw_model (
      .clk_i(clk_i),
      .line_i(sd_out_o),
      .line_o(sd_in_i)
   );

   task automatic close_out();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Waits out the frame gap and the whole own answer byte
   task automatic exchange(input logic [7:0] q[$]);
      u_gw_model.rx_q.delete();
      u_gw_model.send_frame(q);
      repeat (GAP_CYCLES + 12 * BIT_CYCLES) @(negedge clk_i);
   endtask
   task automatic settle();
      repeat (4) @(negedge clk_i);
   endtask

   task automatic t_reset();
      `CHK("line idle", 1'b1, sd_out_o)
      `CHK("outputs", 2'b00, {first_safe_output_o, second_safe_output_o})
      `CHK("response", 8'h00, response_o)
      $display("test reset done");
   endtask
   task automatic t_normal();
      sense_i.guard = 1'b1;
      sense_i.actuator = 1'b1;
      sense_i.first_safe_input = 1'b1;
      sense_i.second_safe_input = 1'b1;
      settle();
      `CHK("outputs", 2'b11, {first_safe_output_o, second_safe_output_o})
      `CHK("response", 8'h33, response_o)
      exchange('{8'h00});
      `CHK("answers", 1, u_gw_model.rx_q.size())
      `CHK("answer", 8'h33, u_gw_model.rx_q[0])
      $display("test normal done");
   endtask
   task automatic t_chain();
      frame.delete();
      for (int i = 0; i < 32; i++) begin
         frame.push_back(8'(i));
      end
      exchange(frame);
      `CHK("chain answers", 31, u_gw_model.rx_q.size())
      `CHK("first forward", 8'h01, u_gw_model.rx_q[0])
      `CHK("last forward", 8'h1e, u_gw_model.rx_q[29])
      `CHK("own answer", 8'h33, u_gw_model.rx_q[30])
      `CHK("request", 8'h00, request_o)
      $display("test chain done");
   endtask
   task automatic t_comm();
      repeat (COMM_T + 100) @(negedge clk_i);
      `CHK("comm error", 1'b1, comm_error_o)
      `CHK("comm detail", 1'b1, warning_detail_o[DET_COMM])
      `CHK("outputs kept", 2'b11, {first_safe_output_o, second_safe_output_o})
      `CHK("no warning", 1'b0, response_o[RESP_WARNING])
      exchange('{8'h01});
      `CHK("comm back", 1'b0, comm_error_o)
      `CHK("detail request", 8'h01, request_o)
      `CHK("detail answers", 1, u_gw_model.rx_q.size())
      `CHK("warn detail answer", 8'h40, u_gw_model.rx_q[0])
      $display("test comm done");
   endtask
   task automatic t_warn();
      sense_i.over_temp = 1'b1;
      settle();
      `CHK("warn response", 8'h73, response_o)
      `CHK("warn detail", 1'b1, warning_detail_o[DET_TEMP])
      sense_i.over_temp = 1'b0;
      settle();
      `CHK("warn cleared", 8'h33, response_o)
      sense_i.out1_err = 1'b1;
      repeat (WARN_T - 20) @(negedge clk_i);
      `CHK("warn outputs", 2'b11, {first_safe_output_o, second_safe_output_o})
      repeat (30) @(negedge clk_i);
      `CHK("warn expired", 2'b00, {first_safe_output_o, second_safe_output_o})
      `CHK("failure flag", 1'b1, response_o[RESP_FAILURE])
      sense_i.out1_err = 1'b0;
      sense_i.guard = 1'b0;
      settle();
      `CHK("guard reset", 1'b0, response_o[RESP_FAILURE])
      `CHK("latched out1", 1'b1, failure_detail_o[DET_OUT1])
      sense_i.guard = 1'b1;
      repeat (6) @(negedge clk_i);
      `CHK("released", 2'b11, {first_safe_output_o, second_safe_output_o})
      `CHK("out1 cleared", 1'b0, failure_detail_o[DET_OUT1])
      $display("test warning done");
   endtask
   task automatic t_fail();
      sense_i.target_err = 1'b1;
      settle();
      `CHK("fail outputs", 2'b00, {first_safe_output_o, second_safe_output_o})
      `CHK("fail detail", 8'h10, failure_detail_o)
      exchange('{8'h81});
      `CHK("reset request", 8'h81, request_o)
      `CHK("detail answer", 8'h10, u_gw_model.rx_q[0])
      sense_i.target_err = 1'b0;
      settle();
      `CHK("still failed", 1'b1, response_o[RESP_FAILURE])
      exchange('{8'h00});
      `CHK("reset by bit7", 1'b0, response_o[RESP_FAILURE])
      `CHK("outputs back", 2'b11, {first_safe_output_o, second_safe_output_o})
      $display("test failure done");
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      close_out();
   end
   initial begin
      repeat (8) @(negedge clk_i);
      srst_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      t_normal();
      t_chain();
      t_comm();
      t_warn();
      t_fail();
      close_out();
   end
endmodule
